// [src/esi_pkg.sv]
// esi_pkg: constants and types shared by the emulator status indicator block.
// assumes a single 25 MHz clock and synchronous active-high reset.
//
// Overview of operation
// - power-up: power, mode red, orange, ready
// - power led only with supply and good voltages
// - stopped mode shows orange, red and green
// - run mode shows green only
// - error holds red; startup red not error
// - ready led steady while unit ready
// - ready led blinks during firmware upgrade
// - ready led off while part loads
// - module present, no target power: hold reset
// - reset options disabled: emulate without target power
// - module absent: core still emulates
// - reset button warm reset, ready after delay
// - serial 115200 baud, 8N1
// - report adapter identification code to host
// - serial uses rts/cts hardware flow control
package esi_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ          = 25_000_000;   // system clock rate
	localparam int unsigned BOOT_RED_MS     = 500;          // red phase of startup
	localparam int unsigned BOOT_READY_S    = 15;           // time until ready
	localparam int unsigned BLINK_MS        = 250;          // blink half period
	localparam int unsigned BAUD            = 115200;       // serial bit rate
	localparam int unsigned DATA_BITS       = 8;            // serial data bits
	localparam int unsigned RED_CYC   = CLK_HZ / 1000 * BOOT_RED_MS;
	localparam int unsigned READY_CYC = CLK_HZ * BOOT_READY_S;
	localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned BIT_CYC   = CLK_HZ / BAUD;     // rounds down: 217
	localparam int unsigned ID_W      = 8;                  // adapter id width
	localparam logic [7:0]  ID_CMD    = 8'h49;              // host query for adapter id

	// ************************************************************
	// mode states
	// ************************************************************
	typedef enum logic [2:0] {
		ESI_OFF   = 3'b000,
		ESI_BOOTR = 3'b001,
		ESI_BOOTO = 3'b010,
		ESI_STOP  = 3'b011,
		ESI_RUN   = 3'b100,
		ESI_ERR   = 3'b101
	} esi_mode_t;
endpackage : esi_pkg

// [src/esi_uart_tx.sv]
// esi_uart_tx: 8n1 serial transmitter paced by clear-to-send.
// assumes cts_in is synchronous to clk_in.
`timescale 1ns/1ps
module esi_uart_tx #(
	parameter int unsigned BIT_CYC = esi_pkg::BIT_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       send_in,    // start request with data
	input  wire logic [7:0] data_in,
	input  wire logic       cts_in,     // host may receive
	output logic            busy_out,
	output logic            txd_out
);
	logic [15:0] cnt;                   // bit timer
	logic [3:0]  idx;                   // bit index, 0 start .. 9 stop
	logic [9:0]  sh;                    // frame shift
	// ************************************************************
	// frame shifter
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			busy_out <= 1'b0;
			txd_out  <= 1'b1;
			cnt      <= 16'h0000;
			idx      <= 4'h0;
			sh       <= 10'h3FF;
		end else if (!busy_out) begin
			// start only while host asserts clear-to-send
			if (send_in && cts_in) begin
				busy_out <= 1'b1;
				sh       <= {1'b1, data_in, 1'b0};
				txd_out  <= 1'b0;
				cnt      <= 16'h0000;
				idx      <= 4'h0;
			end
		end else if (cnt == 16'(BIT_CYC - 1)) begin
			cnt <= 16'h0000;
			if (idx == 4'h9) begin
				busy_out <= 1'b0;
				txd_out  <= 1'b1;
			end else begin
				idx     <= idx + 4'h1;
				txd_out <= sh[idx + 4'h1];
			end
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule : esi_uart_tx

// [src/esi_uart_rx.sv]
// esi_uart_rx: 8n1 serial receiver, samples mid bit.
// assumes rxd_in is synchronous to clk_in.
`timescale 1ns/1ps
module esi_uart_rx #(
	parameter int unsigned BIT_CYC = esi_pkg::BIT_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       rxd_in,
	output logic            valid_out,  // one-cycle pulse
	output logic [7:0]      data_out
);
	logic [15:0] cnt;                   // bit timer
	logic [3:0]  idx;                   // bit index
	logic        act;                   // frame in progress
	// ************************************************************
	// frame receiver
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			act       <= 1'b0;
			cnt       <= 16'h0000;
			idx       <= 4'h0;
			valid_out <= 1'b0;
			data_out  <= 8'h00;
		end else begin
			valid_out <= 1'b0;
			if (!act) begin
				if (!rxd_in) begin
					act <= 1'b1;
					cnt <= 16'h0000;
					idx <= 4'h0;
				end
			end else if (cnt == 16'((idx == 4'h0) ? BIT_CYC / 2 : BIT_CYC - 1)) begin
				cnt <= 16'h0000;
				if (idx == 4'h0 && rxd_in) begin
					act <= 1'b0; // false start
				end else if (idx == 4'h9) begin
					act <= 1'b0;
					valid_out <= rxd_in; // stop bit must be high
				end else begin
					if (idx != 4'h0) data_out <= {rxd_in, data_out[7:1]};
					idx <= idx + 4'h1;
				end
			end else begin
				cnt <= cnt + 16'h0001;
			end
		end
	end
endmodule : esi_uart_rx

// [src/esi_status_ctrl.sv]
// esi_status_ctrl: front-panel indicators, warm reset, target reset hold,
// adapter id report over the host serial link.
// assumes all inputs synchronous to clk_in; leds active high.
`timescale 1ns/1ps
module esi_status_ctrl #(
	parameter int unsigned READY_CYC = esi_pkg::READY_CYC,
	parameter int unsigned RED_CYC   = esi_pkg::RED_CYC,
	parameter int unsigned BLINK_CYC = esi_pkg::BLINK_CYC,
	parameter int unsigned BIT_CYC   = esi_pkg::BIT_CYC
) (
	input  wire logic                     clk_in,
	input  wire logic                     sys_rst_in,
	input  wire logic                     supply_on_in,     // power switch on
	input  wire logic                     volt_ok_in,       // internal rails good
	input  wire logic                     reset_btn_in,     // front reset button
	input  wire logic                     run_in,           // core executing
	input  wire logic                     error_in,         // emulator fault
	input  wire logic                     upgrade_in,       // firmware upgrade busy
	input  wire logic                     part_load_in,     // part loading busy
	input  wire logic                     io_mod_present_in,// io module inserted
	input  wire logic                     target_pwr_in,    // target power present
	input  wire logic                     por_option_in,    // power-on reset option
	input  wire logic                     brownout_reset_option_in,
	input  wire logic [esi_pkg::ID_W-1:0] adapter_id_in,    // adapter id code
	input  wire logic                     rxd_in,           // host serial in
	input  wire logic                     cts_in,           // host may receive
	output logic                          txd_out,
	output logic                          rts_out,          // we may receive
	output logic                          power_led_out,
	output logic                          mode_red_out,
	output logic                          mode_green_out,
	output logic                          ready_led_out,
	output logic                          core_rst_out,     // emulated core reset
	output logic                          ready_out         // unit ready
);
	// ************************************************************
	// declarations
	// ************************************************************
	esi_pkg::esi_mode_t mode, next_mode;   // mode state
	logic [31:0] tmr;                      // startup timer
	logic [31:0] blink_cnt;                // blink divider
	logic        blink;                    // blink phase
	logic        btn_q;                    // button edge history
	logic        warm;                     // warm reset pulse
	logic        pwr_good;                 // supply and rails good
	logic        rx_v;                     // received byte strobe
	logic [7:0]  rx_d;                     // received byte
	logic        tx_busy;                  // transmitter busy
	logic        tx_go;                    // id report request
	logic        hold;                     // pending id report

	// ************************************************************
	// helpers
	// ************************************************************
	// the unit is ready for emulation in stopped or run mode
	function automatic logic is_ready(input esi_pkg::esi_mode_t m);
		return (m == esi_pkg::ESI_STOP) || (m == esi_pkg::ESI_RUN);
	endfunction : is_ready

	assign pwr_good = supply_on_in && volt_ok_in;
	assign warm     = reset_btn_in && !btn_q;

	// ************************************************************
	// power led
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) power_led_out <= 1'b0;
		else power_led_out <= pwr_good;
	end

	// a dark supply or a bad rail puts the led out on the next edge
	property p_pwr_off;
		@(posedge clk_in) disable iff (sys_rst_in) !pwr_good |=> !power_led_out;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power led lit without power");

	// ************************************************************
	// button edge
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) btn_q <= 1'b0;
		else btn_q <= reset_btn_in;
	end

	// ************************************************************
	// startup timer, restarted by power loss or warm reset
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !pwr_good || warm) tmr <= 32'h0000_0000;
		// the count parks at the ready mark so the unit stays ready
		else if (tmr != 32'(READY_CYC)) tmr <= tmr + 32'h0000_0001;
	end

	// ************************************************************
	// mode state machine
	// ************************************************************
	always_comb begin
		next_mode = mode;
		case (mode)
			esi_pkg::ESI_OFF:   if (pwr_good) next_mode = esi_pkg::ESI_BOOTR;
			// red during boot is not an error
			esi_pkg::ESI_BOOTR: if (tmr >= 32'(RED_CYC)) next_mode = esi_pkg::ESI_BOOTO;
			esi_pkg::ESI_BOOTO: if (tmr == 32'(READY_CYC)) next_mode = esi_pkg::ESI_STOP;
			esi_pkg::ESI_STOP:  if (error_in) next_mode = esi_pkg::ESI_ERR;
			                    else if (run_in) next_mode = esi_pkg::ESI_RUN;
			esi_pkg::ESI_RUN:   if (error_in) next_mode = esi_pkg::ESI_ERR;
			                    else if (!run_in) next_mode = esi_pkg::ESI_STOP;
			esi_pkg::ESI_ERR:   next_mode = esi_pkg::ESI_ERR; // held until reset
			default:            next_mode = esi_pkg::ESI_OFF;
		endcase
		// power loss and the reset button override every state
		if (!pwr_good) next_mode = esi_pkg::ESI_OFF;
		else if (warm) next_mode = esi_pkg::ESI_BOOTR;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) mode <= esi_pkg::ESI_OFF;
		else mode <= next_mode;
	end

	// ************************************************************
	// mode led decode
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mode_red_out   <= 1'b0;
			mode_green_out <= 1'b0;
		end else begin
			case (next_mode)
				esi_pkg::ESI_BOOTR, esi_pkg::ESI_ERR: begin
					mode_red_out   <= 1'b1;
					mode_green_out <= 1'b0;
				end
				esi_pkg::ESI_BOOTO, esi_pkg::ESI_STOP: begin
					mode_red_out   <= 1'b1;
					mode_green_out <= 1'b1;
				end
				esi_pkg::ESI_RUN: begin
					mode_red_out   <= 1'b0;
					mode_green_out <= 1'b1;
				end
				default: begin
					mode_red_out   <= 1'b0;
					mode_green_out <= 1'b0;
				end
			endcase
		end
	end

	// boot shows red first, then orange; error shows red alone
	property p_boot;
		@(posedge clk_in) disable iff (sys_rst_in)
			mode == esi_pkg::ESI_BOOTR |-> mode_red_out && !mode_green_out;
	endproperty
	a_boot: assert property (p_boot) else $error("boot not red");
	property p_boot_o;
		@(posedge clk_in) disable iff (sys_rst_in)
			mode == esi_pkg::ESI_BOOTO |-> mode_red_out && mode_green_out;
	endproperty
	a_boot_o: assert property (p_boot_o) else $error("boot not orange");
	property p_err_red;
		@(posedge clk_in) disable iff (sys_rst_in)
			mode == esi_pkg::ESI_ERR |-> mode_red_out && !mode_green_out;
	endproperty
	a_err_red: assert property (p_err_red) else $error("error not red");

	// ************************************************************
	// blink divider
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !upgrade_in) begin
			blink_cnt <= 32'h0000_0000;
			blink     <= 1'b1;
		end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
			blink_cnt <= 32'h0000_0000;
			blink     <= !blink;
		end else blink_cnt <= blink_cnt + 32'h0000_0001;
	end

	// ************************************************************
	// ready led
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ready_led_out <= 1'b0;
			ready_out     <= 1'b0;
		end else begin
			ready_out <= is_ready(next_mode);
			if (part_load_in) ready_led_out <= 1'b0;
			else if (upgrade_in) ready_led_out <= blink;
			else ready_led_out <= is_ready(next_mode);
		end
	end

	// outside load and upgrade the led shows the ready state
	property p_ready;
		@(posedge clk_in) disable iff (sys_rst_in)
			(!part_load_in && !upgrade_in) |=> ready_led_out == ready_out;
	endproperty
	a_ready: assert property (p_ready) else $error("ready led not steady");
	// during an upgrade the led copies the blink phase of the previous edge
	property p_blink;
		@(posedge clk_in) disable iff (sys_rst_in)
			(upgrade_in && !part_load_in) |=> ready_led_out == $past(blink);
	endproperty
	a_blink: assert property (p_blink) else $error("ready led not blinking");

	// ************************************************************
	// emulated core reset: not ready, or io module without target power with a reset option set
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) core_rst_out <= 1'b1;
		// module absent: core runs alone
		else core_rst_out <= !ready_out ||
		                     (io_mod_present_in && !target_pwr_in &&
		                      (por_option_in || brownout_reset_option_in));
	end

	// the brownout option alone also holds the core without target power
	property p_hold_bo;
		@(posedge clk_in) disable iff (sys_rst_in)
			(io_mod_present_in && !target_pwr_in && brownout_reset_option_in) |=> core_rst_out;
	endproperty
	a_hold_bo: assert property (p_hold_bo) else $error("core not held by brownout option");
	// with both reset options off a ready unit runs the core
	property p_nopt;
		@(posedge clk_in) disable iff (sys_rst_in)
			(ready_out && !por_option_in && !brownout_reset_option_in) |=> !core_rst_out;
	endproperty
	a_nopt: assert property (p_nopt) else $error("core held with options off");
	// without the io module a ready unit runs the core
	property p_free;
		@(posedge clk_in) disable iff (sys_rst_in)
			(ready_out && !io_mod_present_in) |=> !core_rst_out;
	endproperty
	a_free: assert property (p_free) else $error("core held without module");

	// ************************************************************
	// host link: id query answered with adapter code
	// ************************************************************
	esi_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.rxd_in     (rxd_in),
		.valid_out  (rx_v),
		.data_out   (rx_d)
	);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) hold <= 1'b0;
		else if (rx_v && rx_d == esi_pkg::ID_CMD) hold <= 1'b1;
		else if (tx_go) hold <= 1'b0;
	end
	// clear-to-send low keeps the reply pending; a frame is never cut
	assign tx_go = hold && !tx_busy && cts_in;

	// receiver never stalls, so ready to accept whenever out of reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) rts_out <= 1'b0;
		else rts_out <= 1'b1;
	end

	esi_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.send_in    (tx_go),
		.data_in    (adapter_id_in),
		.cts_in     (cts_in),
		.busy_out   (tx_busy),
		.txd_out    (txd_out)
	);

	// an idle transmitter keeps the line at the mark level
	property p_txidle;
		@(posedge clk_in) disable iff (sys_rst_in) !tx_busy |-> txd_out;
	endproperty
	a_txidle: assert property (p_txidle) else $error("line not idle high");

	// ************************************************************
	// checks
	// ************************************************************
	property p_pwr;
		@(posedge clk_in) disable iff (sys_rst_in) pwr_good |=> power_led_out;
	endproperty
	a_pwr: assert property (p_pwr) else $error("power led not lit");
	property p_stop;
		@(posedge clk_in) disable iff (sys_rst_in) mode == esi_pkg::ESI_STOP |-> mode_red_out && mode_green_out;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not orange");
	property p_run;
		@(posedge clk_in) disable iff (sys_rst_in) mode == esi_pkg::ESI_RUN |-> !mode_red_out && mode_green_out;
	endproperty
	a_run: assert property (p_run) else $error("run not green");
	property p_err;
		@(posedge clk_in) disable iff (sys_rst_in) (mode == esi_pkg::ESI_ERR && pwr_good && !warm) |=> mode == esi_pkg::ESI_ERR;
	endproperty
	a_err: assert property (p_err) else $error("error not held");
	property p_load;
		@(posedge clk_in) disable iff (sys_rst_in) part_load_in |=> !ready_led_out;
	endproperty
	a_load: assert property (p_load) else $error("ready led lit during load");
	property p_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
			(io_mod_present_in && !target_pwr_in && por_option_in) |=> core_rst_out;
	endproperty
	a_hold: assert property (p_hold) else $error("core not held");
	property p_warm;
		@(posedge clk_in) disable iff (sys_rst_in) (warm && pwr_good) |=> mode == esi_pkg::ESI_BOOTR ##1 !ready_out;
	endproperty
	a_warm: assert property (p_warm) else $error("warm reset ignored");
	property p_cts;
		@(posedge clk_in) disable iff (sys_rst_in) (!cts_in && !tx_busy) |=> !tx_busy;
	endproperty
	a_cts: assert property (p_cts) else $error("sent without cts");
endmodule : esi_status_ctrl

// [tb/esi_host_model.sv]
// esi_host_model: behavioural host on the serial link, 8n1 with rts/cts pacing.
// assumes the device serial lines are synchronous to clk_in and idle high.
`timescale 1ns/1ps
module esi_host_model #(
	parameter int unsigned BIT_CYC = 8
) (
	input  wire logic clk_in,
	input  wire logic txd_in,   // device to host
	input  wire logic rts_in,   // device may receive
	output logic      rxd_out,  // host to device
	output logic      cts_out   // host may receive
);
	// ************************************************************
	// line drivers
	// ************************************************************
	initial begin
		rxd_out = 1'b1;  // idle mark level
		cts_out = 1'b1;  // host ready by default
	end

	// change the host ready level at a clock edge
	task set_cts(input logic v);
		@(posedge clk_in);
		cts_out <= v;
	endtask : set_cts

	// send one frame: start, eight bits lsb first, one stop
	task send_byte(input logic [7:0] b);
		logic [9:0] frame;
		int         n;
		frame = {1'b1, b, 1'b0};
		n = 0;
		// wait at most 1000 cycles for the device to stop holding off, then start the frame
		while (rts_in !== 1'b1 && n < 1000) begin
			@(posedge clk_in);
			n++;
		end
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in);
			rxd_out <= frame[i];
			repeat (BIT_CYC - 1) @(posedge clk_in);
		end
	endtask : send_byte

	// receive one frame within a bounded wait, sampling mid bit
	task recv_byte(output logic [7:0] b, output logic ok);
		int n;
		b = 8'h00;
		n = 0;
		while (txd_in !== 1'b0 && n < 4000) begin
			@(posedge clk_in);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge clk_in);
		ok = (n < 4000) && (txd_in === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_in);
			b[i] = txd_in;
		end
		repeat (BIT_CYC) @(posedge clk_in);
		ok = ok && (txd_in === 1'b1);  // stop bit
	endtask : recv_byte
endmodule : esi_host_model

// [tb/test_emulator_status_indicator_control.sv]
// test_emulator_status_indicator_control: self-checking bench for esi_status_ctrl.
// assumes shortened counts and the host model for the serial side.
`timescale 1ns/1ps
`define ESI_CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
	$display("[FAIL] %s expected %h seen %h", nm, exp, got); error_cnt++; end end
module test_emulator_status_indicator_control;
	localparam int unsigned READY_C = 2000;  // shortened ready time
	localparam int unsigned RED_C   = 200;   // shortened red phase
	localparam int unsigned BLINK_C = 50;    // shortened blink half period
	localparam int unsigned BIT_C   = 8;     // shortened bit time
	logic clk_in = 1'b0, sys_rst_in = 1'b1, supply_on_in = 1'b0, volt_ok_in = 1'b0;
	logic reset_btn_in = 1'b0, run_in = 1'b0, error_in = 1'b0, upgrade_in = 1'b0;
	logic part_load_in = 1'b0, io_mod_present_in = 1'b0, target_pwr_in = 1'b0;
	logic por_option_in = 1'b1, brownout_reset_option_in = 1'b1;
	logic [esi_pkg::ID_W-1:0] adapter_id_in = 8'hA5;  // id carried by the adapter
	logic rxd_in, cts_in, txd_out, rts_out, power_led_out, mode_red_out, mode_green_out;
	logic ready_led_out, core_rst_out, ready_out, ok;
	logic [7:0] rx_b;
	int   error_cnt = 0, comparisons = 0, toggles;

	always #20 clk_in = ~clk_in;  // 25 MHz

	esi_status_ctrl #(.READY_CYC(READY_C), .RED_CYC(RED_C), .BLINK_CYC(BLINK_C), .BIT_CYC(BIT_C)) DUT (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .supply_on_in(supply_on_in), .volt_ok_in(volt_ok_in),
		.reset_btn_in(reset_btn_in), .run_in(run_in), .error_in(error_in), .upgrade_in(upgrade_in),
		.part_load_in(part_load_in), .io_mod_present_in(io_mod_present_in), .target_pwr_in(target_pwr_in),
		.por_option_in(por_option_in), .brownout_reset_option_in(brownout_reset_option_in),
		.adapter_id_in(adapter_id_in), .rxd_in(rxd_in), .cts_in(cts_in), .txd_out(txd_out),
		.rts_out(rts_out), .power_led_out(power_led_out), .mode_red_out(mode_red_out),
		.mode_green_out(mode_green_out), .ready_led_out(ready_led_out), .core_rst_out(core_rst_out),
		.ready_out(ready_out));

	esi_host_model #(.BIT_CYC(BIT_C)) host (
		.clk_in(clk_in), .txd_in(txd_out), .rts_in(rts_out), .rxd_out(rxd_in), .cts_out(cts_in));

	// ************************************************************
	// helpers
	// ************************************************************
	// let n edges pass, then step past the edge so outputs have settled
	task wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_cyc

	// check the two mode elements together
	task chk_mode(input logic r, input logic g);
		`ESI_CHK("mode_red", r, mode_red_out)
		`ESI_CHK("mode_green", g, mode_green_out)
	endtask : chk_mode

	// drive the core reset hold inputs and check the outcome
	task core_case(input logic io, input logic tp, input logic po, input logic bo, input logic exp);
		@(posedge clk_in);
		io_mod_present_in <= io;
		target_pwr_in <= tp;
		por_option_in <= po;
		brownout_reset_option_in <= bo;
		wait_cyc(3);
		`ESI_CHK("core_rst", exp, core_rst_out)
	endtask : core_case

	// query the adapter id and compare the reply
	task id_query(input logic [7:0] id);
		host.send_byte(esi_pkg::ID_CMD);
		host.recv_byte(rx_b, ok);
		`ESI_CHK("id_frame_ok", 1'b1, ok)
		`ESI_CHK("id_reply", id, rx_b)
	endtask : id_query

	// print the verdict and stop
	task complete_run;
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	// ************************************************************
	// tests
	// ************************************************************
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		complete_run();
	end

	initial begin
		wait_cyc(7);
		`ESI_CHK("rst_power_led", 1'b0, power_led_out)
		`ESI_CHK("rst_core_rst", 1'b1, core_rst_out)
		`ESI_CHK("rst_txd", 1'b1, txd_out)
		@(posedge clk_in) sys_rst_in <= 1'b0;
		// supply on but rails bad: power led stays dark
		@(posedge clk_in) supply_on_in <= 1'b1;
		wait_cyc(5);
		`ESI_CHK("power_led_bad_rail", 1'b0, power_led_out)
		`ESI_CHK("rts_ready", 1'b1, rts_out)
		@(posedge clk_in) volt_ok_in <= 1'b1;
		wait_cyc(2);
		`ESI_CHK("power_led", 1'b1, power_led_out)
		wait_cyc(RED_C / 2);
		chk_mode(1'b1, 1'b0);
		`ESI_CHK("core_rst_boot", 1'b1, core_rst_out)
		wait_cyc(RED_C);
		chk_mode(1'b1, 1'b1);
		wait_cyc(READY_C - 2 * RED_C);
		`ESI_CHK("ready_early", 1'b0, ready_led_out)
		wait_cyc(200);
		`ESI_CHK("ready_led", 1'b1, ready_led_out)
		`ESI_CHK("ready", 1'b1, ready_out)
		chk_mode(1'b1, 1'b1);
		// run and stop
		@(posedge clk_in) run_in <= 1'b1;
		wait_cyc(3);
		chk_mode(1'b0, 1'b1);
		@(posedge clk_in) run_in <= 1'b0;
		wait_cyc(3);
		chk_mode(1'b1, 1'b1);
		// firmware upgrade blinks the ready led
		toggles = 0;
		@(posedge clk_in) upgrade_in <= 1'b1;
		wait_cyc(2);
		for (int i = 0; i < 4 * BLINK_C; i++) begin
			rx_b[0] = ready_led_out;
			wait_cyc(1);
			if (ready_led_out !== rx_b[0]) toggles++;
		end
		`ESI_CHK("blink_toggles", 1'b1, toggles >= 3 && toggles <= 5)
		// part loading forces the led off, even over the blink
		@(posedge clk_in) part_load_in <= 1'b1;
		wait_cyc(BLINK_C + 3);
		`ESI_CHK("load_led", 1'b0, ready_led_out)
		@(posedge clk_in) upgrade_in <= 1'b0;
		wait_cyc(3);
		`ESI_CHK("load_led_steady", 1'b0, ready_led_out)
		@(posedge clk_in) part_load_in <= 1'b0;
		wait_cyc(3);
		`ESI_CHK("loaded_led", 1'b1, ready_led_out)
		// core reset hold combinations
		core_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		core_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		core_case(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		core_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		core_case(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		// adapter id over the link, prompt host then a stalling host
		id_query(8'hA5);
		@(posedge clk_in) adapter_id_in <= 8'h3C;
		host.set_cts(1'b0);
		host.send_byte(esi_pkg::ID_CMD);
		toggles = 0;
		for (int i = 0; i < 30 * BIT_C; i++) begin
			wait_cyc(1);
			if (txd_out !== 1'b1) toggles++;
		end
		`ESI_CHK("tx_held_by_cts", 0, toggles)
		fork
			host.recv_byte(rx_b, ok);
			host.set_cts(1'b1);
		join
		`ESI_CHK("stalled_reply", 8'h3C, rx_b)
		`ESI_CHK("stalled_frame", 1'b1, ok)
		// error holds red after the cause goes away
		@(posedge clk_in) error_in <= 1'b1;
		wait_cyc(3);
		@(posedge clk_in) error_in <= 1'b0;
		wait_cyc(20);
		chk_mode(1'b1, 1'b0);
		// warm reset from the button restarts configuration
		@(posedge clk_in) reset_btn_in <= 1'b1;
		wait_cyc(4);
		@(posedge clk_in) reset_btn_in <= 1'b0;
		wait_cyc(5);
		`ESI_CHK("warm_not_ready", 1'b0, ready_out)
		wait_cyc(READY_C + 200);
		`ESI_CHK("warm_ready_led", 1'b1, ready_led_out)
		chk_mode(1'b1, 1'b1);
		// power loss darkens the power led
		@(posedge clk_in) volt_ok_in <= 1'b0;
		wait_cyc(3);
		`ESI_CHK("power_led_off", 1'b0, power_led_out)
		complete_run();
	end
endmodule : test_emulator_status_indicator_control
